//--- src/tdm_codec_serial_port.sv
`timescale 1ns/1ns
// What this block does
// - release data out right after the slot's last bit
// - data slot sends adc word; control slot sends read value or zeros
// - first bit, the msb, is driven at the frame pulse fall
// - input words msb first from frame start; data words go to dac
// - in 15+1 format an input lsb of 1 leaves continuous mode
// - frame pulse drives out as master, is input as slave
// - master frame rate is master clock over 16 x p x n x m
// - delayed frame out feeds the next codec's frame pulse
// - standalone slave drives frame pulse low for 132 master clocks
// - sample rate is frame rate over a factor from control 3 bits 2..0
// - programming frame holds data slots then control slots, 16 bits each
// - programming frame uses 32 bits per codec
// - continuous bit set removes control frame; data words back to back
// - with 16-bit format, continuous ends only by write of 0 or reset
// - mode factor is 1 continuous, 2 programming
// - continuous bit clears itself on return to programming mode
// - control word: address, read flag, broadcast, value in low byte
module tdm_codec_serial_port #(
    parameter int P_DIV = 4,
    parameter int N_DIV = 2,
    parameter int M_DIV = 1
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_role_master,
    input  wire logic        i_cascade,
    input  wire logic [4:0]  i_codec_count,
    input  wire logic        i_sclk_in,
    output logic             o_sclk_out,
    output logic             o_sclk_oe_b,
    input  wire logic        i_fp_in,
    output logic             o_fp_out,
    output logic             o_fp_oe_b,
    output logic             o_fsd,
    input  wire logic        i_din,
    output logic             o_dout,
    output logic             o_dout_oe_b,
    input  wire logic [15:0] i_adc_data,
    input  wire logic        i_adc_ovf,
    input  wire logic        i_dac_ovf,
    output logic      [15:0] o_dac_data,
    output logic             o_dac_strobe,
    output logic             o_adc_take,
    input  wire logic [2:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    output logic             o_cont_mode
);

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [7:0]  DIV_LAST   = 8'(P_DIV - 1);
    localparam logic [7:0]  DIV_HALF   = 8'(P_DIV / 2);
    localparam logic [15:0] FRAME_LAST =
        16'(tdm_pkg::SLOT_BITS * N_DIV * M_DIV - 1);
    localparam logic [23:0] FRAME_MCLK =
        24'(tdm_pkg::SLOT_BITS * P_DIV * N_DIV * M_DIV);

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic [9:0]              sync_q;
    logic                    role_master;
    logic                    cascade;
    logic [4:0]              ncodec;
    logic                    sclk_s;
    logic                    fp_s;
    logic                    din_s;
    logic                    sclk_d;
    logic                    fp_at_drive;
    logic [7:0]              div_cnt;
    logic [7:0]              next_div;
    logic [15:0]             fbit;
    logic [15:0]             next_fbit;
    logic                    drive_tick;
    logic                    sample_tick;
    logic                    frame_start;
    tdm_pkg::port_state_t    state;
    logic [7:0]              hold_cnt;
    logic [9:0]              bcnt;
    logic [9:0]              next_bcnt;
    logic [9:0]              flen;
    logic                    cont_active;
    logic [1:0]              kind;
    logic [1:0]              next_kind;
    logic [15:0]             tx;
    logic [15:0]             rx;
    tdm_pkg::ctl_word_t      cw;
    logic                    word_done;
    logic [7:0]              rd_val;
    logic                    ctl_wr;
    logic                    cont_exit;
    logic [7:0]              ctl [0:7];
    logic [2:0]              rate_cnt;
    logic                    take_sample;
    logic [23:0]             gap;
    logic                    gap_seen;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [9:0] frame_bits(input logic [4:0] n,
                                              input logic       cont);
        frame_bits = cont ? {1'b0, n, 4'h0} : {n, 5'h00};
    endfunction

    function automatic logic [1:0] slot_kind(input logic [9:0] b,
                                             input logic [4:0] n,
                                             input logic       cont);
        logic dat;
        logic ctlk;
        dat  = b[9:4] == 6'h00;
        ctlk = !cont && (b[9:4] == {1'b0, n});
        slot_kind = {ctlk, dat};
    endfunction

    function automatic logic reg_valid(input logic [2:0] a);
        reg_valid = (a != tdm_pkg::REG_NOP) && (a <= tdm_pkg::REG_CTL6);
    endfunction

    function automatic logic [7:0] reg_read(input logic [2:0] a);
        logic [7:0] v;
        v = reg_valid(a) ? ctl[a] : 8'h00;
        if (a == tdm_pkg::REG_CTL1) begin
            v[tdm_pkg::ADOVF_BIT] = i_adc_ovf;
            v[tdm_pkg::DAOVF_BIT] = i_dac_ovf;
        end
        reg_read = v;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    tdm_pin_sync #(
        .W (10)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_d     ({i_role_master, i_cascade, i_codec_count,
                   i_sclk_in, i_fp_in, i_din}),
        .o_q     (sync_q)
    );

    assign role_master = sync_q[9];
    assign cascade     = sync_q[8];
    assign ncodec      = sync_q[7:3];
    assign sclk_s      = sync_q[2];
    assign fp_s        = sync_q[1];
    assign din_s       = sync_q[0];

    // ------------------------------------------------------------
    // bit clock and frame pulse timing
    // ------------------------------------------------------------
    assign next_div  = (div_cnt == DIV_LAST) ? 8'h00 : 8'(div_cnt + 8'h01);
    assign next_fbit = (fbit == FRAME_LAST) ? 16'h0000
                                            : 16'(fbit + 16'h0001);
    assign drive_tick  = role_master ? (div_cnt == 8'h00)
                                     : (sclk_s && !sclk_d);
    assign sample_tick = role_master ? (div_cnt == DIV_HALF)
                                     : (!sclk_s && sclk_d);
    assign frame_start = drive_tick && (state != tdm_pkg::ST_HOLD) &&
                         (role_master ? (fbit == FRAME_LAST)
                                      : (fp_at_drive && !fp_s));

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_d      <= 1'b0;
            fp_at_drive <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            if (drive_tick) begin
                fp_at_drive <= fp_s;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt     <= 8'h00;
            fbit        <= 16'h0000;
            o_sclk_out  <= 1'b0;
            o_sclk_oe_b <= 1'b1;
        end else begin
            div_cnt     <= next_div;
            o_sclk_out  <= role_master && (next_div < DIV_HALF);
            o_sclk_oe_b <= !role_master;
            if (drive_tick && role_master) begin
                fbit <= next_fbit;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_fp_out  <= 1'b0;
            o_fp_oe_b <= 1'b1;
        end else if (state == tdm_pkg::ST_HOLD) begin
            o_fp_out  <= 1'b0;
            o_fp_oe_b <= !(role_master || !cascade);
        end else begin
            o_fp_oe_b <= !role_master;
            if (drive_tick) begin
                o_fp_out <= role_master && (next_fbit == FRAME_LAST);
            end
        end
    end

    // ------------------------------------------------------------
    // frame state and bit counting
    // ------------------------------------------------------------
    assign flen      = frame_bits(ncodec, cont_active);
    assign next_bcnt = 10'(bcnt + 10'h001);
    assign kind      = slot_kind(bcnt, ncodec, cont_active);
    assign next_kind = slot_kind(next_bcnt, ncodec, cont_active);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hold_cnt <= 8'h00;
        end else if (state == tdm_pkg::ST_HOLD &&
                     hold_cnt != tdm_pkg::FP_HOLD_CYCLES) begin
            hold_cnt <= 8'(hold_cnt + 8'h01);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= tdm_pkg::ST_HOLD;
        end else begin
            case (state)
                tdm_pkg::ST_HOLD: begin
                    if (hold_cnt == tdm_pkg::FP_HOLD_CYCLES) begin
                        state <= tdm_pkg::ST_IDLE;
                    end
                end
                tdm_pkg::ST_IDLE: begin
                    if (frame_start) begin
                        state <= tdm_pkg::ST_RUN;
                    end
                end
                tdm_pkg::ST_RUN: begin
                    if (frame_start) begin
                        state <= tdm_pkg::ST_RUN;
                    end else if (drive_tick &&
                                 bcnt == 10'(flen - 10'h001)) begin
                        state <= tdm_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= tdm_pkg::ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bcnt        <= 10'h000;
            cont_active <= 1'b0;
        end else if (frame_start) begin
            bcnt        <= 10'h000;
            cont_active <= ctl[tdm_pkg::REG_CTL1][tdm_pkg::CX_BIT];
        end else if (drive_tick && state == tdm_pkg::ST_RUN) begin
            bcnt <= next_bcnt;
        end
    end

    // ------------------------------------------------------------
    // serial data out
    // ------------------------------------------------------------
    always_comb begin
        rd_val = rx[4] ? reg_read(rx[7:5]) : 8'h00;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dout      <= 1'b0;
            o_dout_oe_b <= 1'b1;
            tx          <= 16'h0000;
        end else if (frame_start) begin
            o_dout      <= i_adc_data[15];
            tx          <= {i_adc_data[14:0], 1'b0};
            o_dout_oe_b <= 1'b0;
        end else if (drive_tick && state == tdm_pkg::ST_RUN) begin
            if (next_kind != 2'b00 && next_bcnt < flen) begin
                o_dout_oe_b <= 1'b0;
                if (next_kind[1] && next_bcnt[3:0] == 4'h0) begin
                    o_dout <= 1'b0;
                    tx     <= 16'h0000;
                end else if (next_kind[1] &&
                             next_bcnt[3:0] == tdm_pkg::CTL_SPLIT_BIT) begin
                    o_dout <= rd_val[7];
                    tx     <= {rd_val[6:0], 9'h000};
                end else begin
                    o_dout <= tx[15];
                    tx     <= {tx[14:0], 1'b0};
                end
            end else begin
                o_dout      <= 1'b0;
                o_dout_oe_b <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_fsd <= 1'b0;
        end else if (drive_tick) begin
            o_fsd <= !frame_start && state == tdm_pkg::ST_RUN &&
                     next_bcnt == tdm_pkg::FSD_BIT;
        end
    end

    // ------------------------------------------------------------
    // serial data in
    // ------------------------------------------------------------
    assign cw        = {rx[14:0], din_s};
    assign word_done = sample_tick && state == tdm_pkg::ST_RUN &&
                       bcnt[3:0] == tdm_pkg::LAST_BIT;
    assign ctl_wr    = word_done && !cont_active &&
                       bcnt[9:4] >= {1'b0, ncodec} && bcnt < flen &&
                       !cw.rw && (kind[1] || cw.bc) &&
                       reg_valid(cw.addr);
    assign cont_exit = word_done && kind[0] && cont_active &&
                       !ctl[tdm_pkg::REG_CTL1][tdm_pkg::DAC16_BIT] &&
                       cw.value[0];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx <= 16'h0000;
        end else if (sample_tick && state == tdm_pkg::ST_RUN) begin
            rx <= {rx[14:0], din_s};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dac_data   <= 16'h0000;
            o_dac_strobe <= 1'b0;
        end else begin
            o_dac_strobe <= 1'b0;
            if (word_done && kind[0]) begin
                o_dac_data   <= cw;
                o_dac_strobe <= take_sample;
            end
        end
    end

    // ------------------------------------------------------------
    // sample rate divider
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rate_cnt    <= 3'h0;
            take_sample <= 1'b0;
            o_adc_take  <= 1'b0;
        end else begin
            o_adc_take <= frame_start && rate_cnt == 3'h0;
            if (frame_start) begin
                take_sample <= rate_cnt == 3'h0;
                rate_cnt    <= (rate_cnt == 3'h0)
                    ? ctl[tdm_pkg::REG_CTL3][tdm_pkg::RATE_MSB:0]
                    : 3'(rate_cnt - 3'h1);
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int k = 0; k < 8; k++) begin
                ctl[k] <= tdm_pkg::CTL_RESET;
            end
        end else begin
            if (ctl_wr) begin
                ctl[cw.addr] <= cw.value;
            end
            if (i_wr && reg_valid(i_addr)) begin
                ctl[i_addr] <= i_wdata;
            end
            if (cont_exit) begin
                ctl[tdm_pkg::REG_CTL1][tdm_pkg::CX_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata     <= 8'h00;
            o_cont_mode <= 1'b0;
        end else begin
            o_rdata     <= i_rd ? reg_read(i_addr) : 8'h00;
            o_cont_mode <= cont_active;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gap      <= 24'h000000;
            gap_seen <= 1'b0;
        end else if (frame_start) begin
            gap      <= 24'h000000;
            gap_seen <= 1'b1;
        end else if (gap != 24'hffffff) begin
            gap <= 24'(gap + 24'h000001);
        end
    end

    dout_release_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (state != tdm_pkg::ST_RUN) |-> o_dout_oe_b)
        else $error("data out driven outside a frame");

    dout_msb_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        frame_start |=> (!o_dout_oe_b && o_dout == $past(i_adc_data[15])))
        else $error("msb not driven at frame start");

    ctl_zero_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (drive_tick && state == tdm_pkg::ST_RUN && !frame_start &&
         next_kind[1] && next_bcnt[3:0] == tdm_pkg::CTL_SPLIT_BIT &&
         !rx[4]) |=> (!o_dout && !o_dout_oe_b))
        else $error("control low byte not zero without read");

    cont_exit_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        cont_exit |=> !ctl[tdm_pkg::REG_CTL1][tdm_pkg::CX_BIT])
        else $error("flag bit did not leave continuous mode");

    fp_dir_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (state != tdm_pkg::ST_HOLD && $stable(role_master))
        |=> (o_fp_oe_b == !$past(role_master)))
        else $error("frame pulse direction wrong for role");

    frame_rate_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (role_master && frame_start && gap_seen)
        |-> (gap == 24'(FRAME_MCLK - 24'h000001)))
        else $error("master frame period wrong");

    fsd_pos_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_fsd) |-> (bcnt == tdm_pkg::FSD_BIT))
        else $error("delayed frame out at wrong bit");

    fp_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        ($past(state) == tdm_pkg::ST_HOLD && state != tdm_pkg::ST_HOLD)
        |-> (hold_cnt == tdm_pkg::FP_HOLD_CYCLES && !o_fp_out))
        else $error("initial frame pulse window wrong length");

    dac_rate_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        o_dac_strobe |-> $past(take_sample && word_done && kind[0]))
        else $error("dac strobe outside a sampling frame");

endmodule

//--- src/tdm_pkg.sv
package tdm_pkg;

    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    localparam int         SLOT_BITS      = 16;
    localparam logic [3:0] LAST_BIT       = 4'hf;
    localparam logic [3:0] CTL_SPLIT_BIT  = 4'h8;
    localparam logic [9:0] FSD_BIT        = 10'h00f;
    localparam logic [7:0] FP_HOLD_CYCLES = 8'h84;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    localparam logic [2:0] REG_NOP    = 3'h0;
    localparam logic [2:0] REG_CTL1   = 3'h1;
    localparam logic [2:0] REG_CTL2   = 3'h2;
    localparam logic [2:0] REG_CTL3   = 3'h3;
    localparam logic [2:0] REG_CTL6   = 3'h6;
    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam int         ADOVF_BIT  = 7;
    localparam int         CX_BIT     = 6;
    localparam int         DAOVF_BIT  = 4;
    localparam int         DAC16_BIT  = 0;
    localparam int         TURBO_BIT  = 7;
    localparam int         RATE_MSB   = 2;

    typedef struct packed {
        logic [2:0] addr;
        logic       rw;
        logic       bc;
        logic [2:0] fill;
        logic [7:0] value;
    } ctl_word_t;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_IDLE = 3'b010,
        ST_RUN  = 3'b100
    } port_state_t;

endpackage

//--- src/tdm_pin_sync.sv
`timescale 1ns/1ns
module tdm_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end

endmodule

//--- dv/tdm_dsp_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host dsp, serial slave of the codec
// ----------------------------------------
module tdm_dsp_model (
    input  wire logic        i_clk,
    input  wire logic        i_sclk,
    input  wire logic        i_fp,
    input  wire logic        i_dout,
    input  wire logic        i_dout_oe_b,
    input  wire logic [31:0] i_tx,
    output logic             o_din,
    output logic      [31:0] o_rx,
    output logic      [7:0]  o_bits,
    output logic             o_done
);
    logic        ps;
    logic        pf;
    logic [7:0]  cnt;
    logic [31:0] sh;
    logic [31:0] tx;
    initial begin
        o_din = 1'b0;
        o_done = 1'b0;
    end
    // frame pulse and bit clock only watched, never driven
    // a frame ends at the frame pulse fall, frames run back to back
    always @(posedge i_clk) begin
        ps <= i_sclk;
        pf <= i_fp;
        o_done <= pf === 1'b1 && i_fp === 1'b0;
        if (pf === 1'b1 && i_fp === 1'b0) begin
            o_rx <= sh;
            o_bits <= cnt;
            cnt <= 8'h00;
        end else if (ps === 1'b1 && i_sclk === 1'b0) begin
            cnt <= 8'(cnt + 8'h01);
        end
        if (ps === 1'b1 && i_sclk === 1'b0 && i_dout_oe_b === 1'b0) begin
            sh <= {sh[30:0], i_dout};
        end
        if (i_fp === 1'b1) begin
            tx <= i_tx;
            o_din <= i_tx[31];
        end else if (ps === 1'b1 && i_sclk === 1'b0) begin
            o_din <= tx[30];
            tx <= {tx[30:0], ~tx[0]};
        end
    end
endmodule

//--- dv/tdm_codec_serial_port_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tdm_codec_serial_port_tb;
    localparam int FRAME = 16 * 4 * 2 * 1;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] adc = 16'h0;
    logic        ovf = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] tx = 32'h0;
    logic [7:0]  rdata, rv;
    logic [15:0] dac;
    logic [31:0] rx;
    logic        sclk, fp, fp_oe_b, din, dout, dout_oe_b, take, cont, done;
    logic        sclk_oe_b, delayed_frame_out, stb;
    logic [7:0]  bits;
    int          fsd_n = 0;
    int          stb_n = 0;
    int          fb = 0;
    int          sb = 0;
    int          errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          gap = 0;
    int          per = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    tdm_codec_serial_port #(.P_DIV(4), .N_DIV(2), .M_DIV(1)) dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_role_master(1'b1),
        .i_cascade(1'b0), .i_codec_count(5'h01), .i_sclk_in(1'b0),
        .o_sclk_out(sclk), .o_sclk_oe_b(sclk_oe_b), .i_fp_in(1'b0),
        .o_fp_out(fp), .o_fp_oe_b(fp_oe_b), .o_fsd(delayed_frame_out), .i_din(din),
        .o_dout(dout), .o_dout_oe_b(dout_oe_b), .i_adc_data(adc),
        .i_adc_ovf(ovf), .i_dac_ovf(ovf), .o_dac_data(dac),
        .o_dac_strobe(stb), .o_adc_take(take), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_cont_mode(cont));
    tdm_dsp_model host (.i_clk(clk), .i_sclk(sclk), .i_fp(fp),
        .i_dout(dout), .i_dout_oe_b(dout_oe_b), .i_tx(tx), .o_din(din),
        .o_rx(rx), .o_bits(bits), .o_done(done));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (delayed_frame_out === 1'b1) fsd_n <= fsd_n + 1;
        if (stb === 1'b1) stb_n <= stb_n + 1;
        gap <= take === 1'b1 ? 1 : gap + 1;
        if (take === 1'b1) per <= gap;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    task summarize;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        rv = rdata;
    endtask
    task frames(input int n);
        repeat (n) begin
            @(posedge clk);
            while (done !== 1'b1) @(posedge clk);
        end
    endtask
    task t_hold;
        repeat (20) @(posedge clk);
        `CHK("fp_oe_b", 1'b0, fp_oe_b)
        `CHK("sclk_oe_b", 1'b0, sclk_oe_b)
        `CHK("dout_oe_b", 1'b1, dout_oe_b)
    endtask
    task t_regs;
        rreg(tdm_pkg::REG_CTL1);
        `CHK("ctl1", 8'h90, rv)
        @(posedge clk);
        `CHK("rdata idle", 8'h00, rdata)
        rreg(3'h0);
        `CHK("addr 0", 8'h00, rv)
        rreg(3'h7);
        `CHK("addr 7", 8'h00, rv)
        wreg(tdm_pkg::REG_CTL2, 8'h80);
        rreg(tdm_pkg::REG_CTL2);
        `CHK("ctl2", 8'h80, rv)
    endtask
    task t_frame;
        adc <= 16'ha5c3;
        tx <= {16'h3c5a, tdm_pkg::REG_CTL2, 1'b1, 1'b0, 3'h7, 8'h00};
        frames(3);
        `CHK("adc word", 16'ha5c3, rx[31:16])
        `CHK("read word", 16'h0080, rx[15:0])
        `CHK("dac", 16'h3c5a, dac)
        `CHK("period", FRAME, per)
        `CHK("bit clocks", 8'h20, bits)
        tx <= {16'h3c5a, 16'h0};
        fb = fsd_n;
        sb = stb_n;
        frames(2);
        `CHK("no read", 16'h0, rx[15:0])
        `CHK("fsd", 32'h8, fsd_n - fb)
        `CHK("dac strobes", 32'h2, stb_n - sb)
    endtask
    task t_rate;
        wreg(tdm_pkg::REG_CTL3, 8'h01);
        frames(4);
        `CHK("rate 2", 2 * FRAME, per)
        sb = stb_n;
        frames(4);
        `CHK("sampled frames", 32'h2, stb_n - sb)
        wreg(tdm_pkg::REG_CTL3, 8'h00);
        frames(3);
    endtask
    task t_cont;
        tx <= {16'h1234, 16'h0};
        wreg(tdm_pkg::REG_CTL1, 8'h40);
        frames(3);
        `CHK("cont", 1'b1, cont)
        `CHK("cont word", 16'ha5c3, rx[15:0])
        tx <= {16'h1235, 16'h0};
        frames(3);
        `CHK("flag exit", 1'b0, cont)
        rreg(tdm_pkg::REG_CTL1);
        `CHK("cont bit", 1'b0, rv[6])
        wreg(tdm_pkg::REG_CTL1, 8'h41);
        frames(6);
        `CHK("16 bit stay", 1'b1, cont)
        wreg(tdm_pkg::REG_CTL1, 8'h01);
        frames(3);
        `CHK("write exit", 1'b0, cont)
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_hold;
        t_regs;
        t_frame;
        t_rate;
        t_cont;
        summarize();
    end
endmodule
